/* rtl/irq_bank_pkg.sv */
// Constants, register map and carrier types of the interrupt flag/enable bank
package irq_bank_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_CTRL = 5;
  localparam int NUM_GRP = 6;
  localparam int EVT_W = 8;

  // Byte offsets on the register bus
  localparam logic [7:0] OFS_EDGE = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_CTRL_C = 8'h0c;
  localparam logic [7:0] OFS_CTRL_D = 8'h10;
  localparam logic [7:0] OFS_HALL = 8'h14;
  localparam logic [7:0] OFS_EVT_STAT = 8'h18;
  localparam logic [7:0] OFS_EVT_MASK = 8'h1c;

  // Array index of each flag/enable register
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam int IDX_C = 2;
  localparam int IDX_D = 3;
  localparam int IDX_HALL = 4;
  localparam logic [NUM_CTRL-1:0][7:0] CTRL_OFS =
    {OFS_HALL, OFS_CTRL_D, OFS_CTRL_C, OFS_CTRL_B, OFS_CTRL_A};

  // Implemented bits; all others read zero
  localparam logic [7:0] MASK_EDGE = 8'h03;
  localparam logic [NUM_CTRL-1:0][7:0] CTRL_MASK = {8'h77, 8'hff, 8'hff, 8'hee, 8'h7f};
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RST_EDGE = 2'h0;

  // Bit positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_GRP0_E = 1;
  localparam int BIT_GRP0_F = 4;
  localparam int BIT_EXT0_F = 5;
  localparam int BIT_CMP0_F = 6;
  localparam int BIT_GRP1_E = 1;
  localparam int BIT_GRP1_F = 5;
  localparam int BIT_LVD_F = 6;
  localparam int BIT_OCP_F = 7;
  localparam int BIT_RSVD_HI = 4;
  localparam int BIT_RSVD_LO = 0;
  localparam int BIT_UART_E = 0;
  localparam int BIT_EE_E = 1;
  localparam int BIT_UART_F = 4;
  localparam int BIT_EE_F = 5;
  localparam int BIT_GRP6_F = 6;
  localparam int BIT_TB_E = 3;
  localparam int BIT_TB_F = 7;
  localparam int BIT_HALL_F = 4;
  localparam int BIT_HALL_E = 0;

  // External interrupt 0 edge codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Event status bit positions
  localparam int EVT_CMP0 = 0;
  localparam int EVT_EXT0 = 1;
  localparam int EVT_OCP = 2;
  localparam int EVT_LVD = 3;
  localparam int EVT_TB = 4;
  localparam int EVT_EE = 5;
  localparam int EVT_UART = 6;
  localparam int EVT_HALL = 7;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // One-cycle request pulses from the sources
  typedef struct packed {
    logic cmp0;
    logic ocp;
    logic lvd;
    logic timebase;
    logic eeprom;
    logic uart;
    logic [2:0] hall;
    logic [NUM_GRP-1:0] group;
  } src_evt_t;
endpackage : irq_bank_pkg

/* rtl/irq_flag_bank.sv */
// Interrupt request flag and enable register bank with APB access
// How it works
// - Edge code selects off, rise, fall, both
// - Comparator zero flag in first register bit6
// - External zero flag in first register bit5
// - Bit0 of first register gates the core request only, not irq_o
// - Group zero flag bit4, enable bit1
// - Overcurrent flag in second register bit7
// - Group one flag bit5, enable bit1
// - Groups five..two flags 7..4, enables 3..0
// - Timebase flag bit7, enable bit3, fourth register
// - Eeprom flag bit5, enable bit1, fourth register
// - Serial flag bit4, enable bit0, fourth register
// - Unimplemented bits always read zero
// - Hall flags bits 4..6, enables 0..2
`timescale 1ns/1ns
module irq_flag_bank (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire irq_bank_pkg::apb_req_t apb_req_i,
  output irq_bank_pkg::apb_rsp_t apb_rsp_o,
  // Sources
  input wire logic external_irq_zero_input_i,
  input wire irq_bank_pkg::src_evt_t src_evt_i,
  // Interrupt outputs
  output logic core_irq_o,
  output logic irq_o
);
  import irq_bank_pkg::*;

  logic [7:0] ctrl_ff [NUM_CTRL];
  logic [7:0] nxt_ctrl [NUM_CTRL];
  logic [7:0] ctrl_set [NUM_CTRL];
  logic [1:0] edge_ff;
  logic [1:0] nxt_edge;
  logic ext_prev_ff;
  logic [EVT_W-1:0] evt_stat_ff;
  logic [EVT_W-1:0] nxt_evt_stat;
  logic [EVT_W-1:0] evt_mask_ff;
  logic [EVT_W-1:0] nxt_evt_mask;
  logic [EVT_W-1:0] evt_in;
  apb_rsp_t rsp_ff;
  apb_rsp_t nxt_rsp;
  logic core_irq_ff;
  logic nxt_core_irq;
  logic irq_ff;
  logic nxt_irq;
  logic setup;
  logic wr_en;
  logic ext_rise;
  logic ext_fall;
  logic ext_trig;
  logic grp0_set;
  logic pend;

  assign setup = apb_req_i.psel & ~apb_req_i.penable;
  // Write lands only at the access edge that sees pready
  assign wr_en = apb_req_i.psel & apb_req_i.penable & rsp_ff.pready & apb_req_i.pwrite;

  // Input is taken as synchronous; one flop gives the previous level
  assign ext_rise = external_irq_zero_input_i & ~ext_prev_ff;
  assign ext_fall = ~external_irq_zero_input_i & ext_prev_ff;

  always_comb begin
    unique case (edge_ff)
      EDGE_OFF: ext_trig = 1'b0;
      EDGE_RISE: ext_trig = ext_rise;
      EDGE_FALL: ext_trig = ext_fall;
      EDGE_BOTH: ext_trig = ext_rise | ext_fall;
    endcase
  end

  // Group zero is fed by its enabled hall flags, not the raw hall pulses
  assign grp0_set = |(ctrl_ff[IDX_HALL][BIT_HALL_F+2:BIT_HALL_F] &
                      ctrl_ff[IDX_HALL][BIT_HALL_E+2:BIT_HALL_E]);

  // Hardware set vectors, one per register
  always_comb begin
    for (int k = 0; k < NUM_CTRL; k++) begin
      ctrl_set[k] = RST_REG;
    end
    ctrl_set[IDX_A][BIT_CMP0_F] = src_evt_i.cmp0;
    ctrl_set[IDX_A][BIT_EXT0_F] = ext_trig;
    ctrl_set[IDX_A][BIT_GRP0_F] = grp0_set;
    ctrl_set[IDX_B][BIT_OCP_F] = src_evt_i.ocp;
    ctrl_set[IDX_B][BIT_LVD_F] = src_evt_i.lvd;
    ctrl_set[IDX_B][BIT_GRP1_F] = src_evt_i.group[0];
    ctrl_set[IDX_C][7:4] = src_evt_i.group[4:1];
    ctrl_set[IDX_D][BIT_TB_F] = src_evt_i.timebase;
    ctrl_set[IDX_D][BIT_GRP6_F] = src_evt_i.group[5];
    ctrl_set[IDX_D][BIT_EE_F] = src_evt_i.eeprom;
    ctrl_set[IDX_D][BIT_UART_F] = src_evt_i.uart;
    ctrl_set[IDX_HALL][BIT_HALL_F+2:BIT_HALL_F] = src_evt_i.hall;
  end

  // Flag/enable registers; a source set beats a clearing write
  for (genvar i = 0; i < NUM_CTRL; i++) begin : g_ctrl
    always_comb begin
      nxt_ctrl[i] = ctrl_ff[i];
      if (wr_en && apb_req_i.paddr == CTRL_OFS[i]) begin
        nxt_ctrl[i] = apb_req_i.pwdata[7:0];
      end
      nxt_ctrl[i] = (nxt_ctrl[i] | ctrl_set[i]) & CTRL_MASK[i];
    end

    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        ctrl_ff[i] <= RST_REG;
      end else begin
        ctrl_ff[i] <= nxt_ctrl[i];
      end
    end
  end

  // Edge select and event status/mask
  assign evt_in = {|src_evt_i.hall, src_evt_i.uart, src_evt_i.eeprom, src_evt_i.timebase,
                   src_evt_i.lvd, src_evt_i.ocp, ext_trig, src_evt_i.cmp0};

  always_comb begin
    nxt_edge = edge_ff;
    nxt_evt_mask = evt_mask_ff;
    nxt_evt_stat = evt_stat_ff;
    if (wr_en && apb_req_i.paddr == OFS_EDGE) begin
      nxt_edge = apb_req_i.pwdata[1:0];
    end
    if (wr_en && apb_req_i.paddr == OFS_EVT_MASK) begin
      nxt_evt_mask = apb_req_i.pwdata[EVT_W-1:0];
    end
    if (wr_en && apb_req_i.paddr == OFS_EVT_STAT) begin
      nxt_evt_stat = evt_stat_ff & ~apb_req_i.pwdata[EVT_W-1:0];
    end
    // Set after clear so a same-cycle event is kept
    nxt_evt_stat = nxt_evt_stat | evt_in;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      edge_ff <= RST_EDGE;
      ext_prev_ff <= 1'b0;
      evt_stat_ff <= '0;
      evt_mask_ff <= '0;
    end else begin
      edge_ff <= nxt_edge;
      ext_prev_ff <= external_irq_zero_input_i;
      evt_stat_ff <= nxt_evt_stat;
      evt_mask_ff <= nxt_evt_mask;
    end
  end

  // Request to the core; flag and enable pairs per register
  always_comb begin
    pend = |(ctrl_ff[IDX_A][BIT_CMP0_F:BIT_GRP0_F] & ctrl_ff[IDX_A][BIT_CMP0_F-3:BIT_GRP0_E]);
    pend = pend | |(ctrl_ff[IDX_B][7:5] & ctrl_ff[IDX_B][3:1]);
    pend = pend | |(ctrl_ff[IDX_C][7:4] & ctrl_ff[IDX_C][3:0]);
    pend = pend | |(ctrl_ff[IDX_D][7:4] & ctrl_ff[IDX_D][3:0]);
    nxt_core_irq = ctrl_ff[IDX_A][BIT_GLOBAL_EN] & pend;
    nxt_irq = |(evt_stat_ff & evt_mask_ff);
  end

  // Read data captured in setup so pready and prdata come from flops
  always_comb begin
    nxt_rsp = '0;
    if (setup) begin
      nxt_rsp.pready = 1'b1;
      unique case (apb_req_i.paddr)
        OFS_EDGE: nxt_rsp.prdata[7:0] = {6'h00, edge_ff};
        OFS_CTRL_A: nxt_rsp.prdata[7:0] = ctrl_ff[IDX_A];
        OFS_CTRL_B: nxt_rsp.prdata[7:0] = ctrl_ff[IDX_B];
        OFS_CTRL_C: nxt_rsp.prdata[7:0] = ctrl_ff[IDX_C];
        OFS_CTRL_D: nxt_rsp.prdata[7:0] = ctrl_ff[IDX_D];
        OFS_HALL: nxt_rsp.prdata[7:0] = ctrl_ff[IDX_HALL];
        OFS_EVT_STAT: nxt_rsp.prdata[EVT_W-1:0] = evt_stat_ff;
        OFS_EVT_MASK: nxt_rsp.prdata[EVT_W-1:0] = evt_mask_ff;
        default: nxt_rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rsp_ff <= '0;
      core_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      rsp_ff <= nxt_rsp;
      core_irq_ff <= nxt_core_irq;
      irq_ff <= nxt_irq;
    end
  end

  assign apb_rsp_o = rsp_ff;
  assign core_irq_o = core_irq_ff;
  assign irq_o = irq_ff;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  logic wr_a;
  logic wr_d;
  assign wr_a = wr_en && apb_req_i.paddr == OFS_CTRL_A;
  assign wr_d = wr_en && apb_req_i.paddr == OFS_CTRL_D;

  edge_rise_a: assert property (ext_rise && edge_ff == EDGE_RISE |=> ctrl_ff[IDX_A][5])
    else $error("rising edge did not set external flag");
  edge_off_a: assert property (edge_ff == EDGE_OFF && !wr_a && !ctrl_ff[IDX_A][5]
    |=> !ctrl_ff[IDX_A][5])
    else $error("external flag set while edge trigger disabled");
  cmp_flag_a: assert property (src_evt_i.cmp0 |=> ctrl_ff[IDX_A][6])
    else $error("comparator request not flagged in bit 6");
  global_gate_a: assert property (!ctrl_ff[IDX_A][0] |=> !core_irq_o)
    else $error("core request while global enable clear");
  grp0_feed_a: assert property (src_evt_i.hall[0] && ctrl_ff[IDX_HALL][0]
    |=> ctrl_ff[IDX_HALL][4] ##1 ctrl_ff[IDX_A][4])
    else $error("hall A request did not reach group zero flag");
  ocp_flag_a: assert property (src_evt_i.ocp |=> ctrl_ff[IDX_B][7])
    else $error("overcurrent request not flagged in bit 7");
  grp1_flag_a: assert property (src_evt_i.group[0] |=> ctrl_ff[IDX_B][5])
    else $error("group one request not flagged in bit 5");
  grp5_flag_a: assert property (src_evt_i.group[4] |=> ctrl_ff[IDX_C][7])
    else $error("group five request not flagged in bit 7");
  tb_flag_a: assert property (src_evt_i.timebase |=> ctrl_ff[IDX_D][7])
    else $error("timebase request not flagged in bit 7");
  ee_flag_a: assert property (src_evt_i.eeprom |=> ctrl_ff[IDX_D][5])
    else $error("eeprom request not flagged in bit 5");
  reserved_zero_a: assert property (ctrl_ff[IDX_B][4] == 1'b0 && ctrl_ff[IDX_B][0] == 1'b0
    && !ctrl_ff[IDX_A][7] && !ctrl_ff[IDX_HALL][7] && !ctrl_ff[IDX_HALL][3])
    else $error("reserved bit reads nonzero");
  uart_path_a: assert property (ctrl_ff[IDX_A][0] && ctrl_ff[IDX_D][4] && ctrl_ff[IDX_D][0]
    |=> core_irq_o)
    else $error("enabled serial request did not reach core");
  flag_clear_a: assert property (wr_d && apb_req_i.pwdata[7:0] == 8'h00 && !src_evt_i.uart
    |=> !ctrl_ff[IDX_D][4] && !ctrl_ff[IDX_D][0])
    else $error("software write did not clear serial flag");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst_i |=> ctrl_ff[IDX_C] == 8'h00
    && edge_ff == 2'h0 && !core_irq_o)
    else $error("reset did not clear bank");
  uart_flag_a: assert property (src_evt_i.uart
    |=> ctrl_ff[IDX_D][4])
    else $error("serial request not flagged in bit 4");
  hall_b_flag_a: assert property (src_evt_i.hall[1]
    |=> ctrl_ff[IDX_HALL][5])
    else $error("hall B request not flagged in bit 5");
  hall_c_flag_a: assert property (src_evt_i.hall[2]
    |=> ctrl_ff[IDX_HALL][6])
    else $error("hall C request not flagged in bit 6");
  grp2_flag_a: assert property (src_evt_i.group[1]
    |=> ctrl_ff[IDX_C][4])
    else $error("group two request not flagged in bit 4");
  grp3_flag_a: assert property (src_evt_i.group[2]
    |=> ctrl_ff[IDX_C][5])
    else $error("group three request not flagged in bit 5");
  grp4_flag_a: assert property (src_evt_i.group[3]
    |=> ctrl_ff[IDX_C][6])
    else $error("group four request not flagged in bit 6");
  edge_fall_a: assert property (ext_fall && edge_ff == EDGE_FALL
    |=> ctrl_ff[IDX_A][5])
    else $error("falling edge did not set external flag");
  edge_both_a: assert property ((ext_rise || ext_fall) && edge_ff == EDGE_BOTH
    |=> ctrl_ff[IDX_A][5])
    else $error("edge in dual mode did not set external flag");
  rise_only_a: assert property (edge_ff == EDGE_RISE && !ext_rise && !wr_a && !ctrl_ff[IDX_A][5]
    |=> !ctrl_ff[IDX_A][5])
    else $error("external flag set without rising edge");
  no_flag_a: assert property (ctrl_ff[IDX_A][6:4] == 3'h0 && ctrl_ff[IDX_B] == 8'h00
    && ctrl_ff[IDX_C] == 8'h00 && ctrl_ff[IDX_D] == 8'h00 |=> !core_irq_o)
    else $error("core request with no flag set");
  ocp_path_a: assert property (ctrl_ff[IDX_A][0] && ctrl_ff[IDX_B][7] && ctrl_ff[IDX_B][3]
    |=> core_irq_o)
    else $error("enabled overcurrent request did not reach core");
  grp0_path_a: assert property (ctrl_ff[IDX_A][0] && ctrl_ff[IDX_A][4] && ctrl_ff[IDX_A][1]
    |=> core_irq_o)
    else $error("enabled group zero request did not reach core");
  hall_feed_a: assert property (ctrl_ff[IDX_HALL][4] && ctrl_ff[IDX_HALL][0]
    |=> ctrl_ff[IDX_A][4])
    else $error("enabled hall A flag did not feed group zero");
  write_lands_a: assert property (wr_d && !src_evt_i.timebase && !src_evt_i.group[5]
    && !src_evt_i.eeprom && !src_evt_i.uart |=> ctrl_ff[IDX_D] == $past(apb_req_i.pwdata[7:0]))
    else $error("write to fourth register did not land");
  upper_zero_a: assert property (rsp_ff.pready
    |-> rsp_ff.prdata[31:8] == 24'h000000)
    else $error("upper read data bits nonzero");
  reset_bank_a: assert property (disable iff (1'b0) sys_rst_i
    |=> ctrl_ff[IDX_A] == 8'h00 && ctrl_ff[IDX_B] == 8'h00 && ctrl_ff[IDX_D] == 8'h00 && !irq_o)
    else $error("reset did not clear flag registers");
  evt_keep_a: assert property (evt_in[EVT_CMP0]
    |=> evt_stat_ff[EVT_CMP0])
    else $error("comparator event lost in status");
  ee_path_a: assert property (ctrl_ff[IDX_A][0] && ctrl_ff[IDX_D][5] && ctrl_ff[IDX_D][1]
    |=> core_irq_o)
    else $error("enabled eeprom request did not reach core");
  tb_path_a: assert property (ctrl_ff[IDX_A][0] && ctrl_ff[IDX_D][7] && ctrl_ff[IDX_D][3]
    |=> core_irq_o)
    else $error("enabled timebase request did not reach core");
  grp_c_path_a: assert property (ctrl_ff[IDX_A][0] && |(ctrl_ff[IDX_C][7:4] & ctrl_ff[IDX_C][3:0])
    |=> core_irq_o)
    else $error("enabled group request did not reach core");

  uart_irq_c: cover property (src_evt_i.uart ##1 ctrl_ff[IDX_D][0] ##1 core_irq_o);
  both_edge_c: cover property (edge_ff == EDGE_BOTH && ext_fall ##1 ctrl_ff[IDX_A][5]);
  evt_irq_c: cover property (evt_in[EVT_HALL] && evt_mask_ff[EVT_HALL] ##1 irq_o);
  unmapped_c: cover property (rsp_ff.pslverr);
endmodule : irq_flag_bank

/* sim/core_seq_model.sv */
// Core-side model that takes level interrupt requests from the bank
`timescale 1ns/1ns
module core_seq_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Request from the bank
  input wire logic core_irq_i,
  // Requests taken so far
  output logic [15:0] take_cnt_o
);
  logic irq_q_ff;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_q_ff <= 1'b0;
      take_cnt_o <= 16'h0000;
    end else begin
      irq_q_ff <= core_irq_i;
      // A level request counts once, at its rise
      if (core_irq_i && !irq_q_ff) begin
        take_cnt_o <= take_cnt_o + 16'h0001;
      end
    end
  end
endmodule : core_seq_model

/* sim/primary_interrupt_flag_enable_bank_tb.sv */
// Testbench for the interrupt flag and enable bank
`timescale 1ns/1ns
module primary_interrupt_flag_enable_bank_tb;
  import irq_bank_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  src_evt_t src = '0;
  logic ext = 1'b0;
  logic core_irq;
  logic irq;
  logic [15:0] takes;
  logic [31:0] q;
  logic err;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  // Source bit in src_evt_t, register offset, flag bit
  localparam int SP[15] = '{14, 13, 12, 11, 10, 9, 6, 7, 8, 0, 1, 2, 3, 4, 5};
  localparam logic [7:0] SO[15] = '{8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10, 8'h14, 8'h14,
    8'h14, 8'h08, 8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h10};
  localparam int SB[15] = '{6, 7, 6, 7, 5, 4, 4, 5, 6, 5, 4, 5, 6, 7, 6};
  localparam logic [7:0] RM[6] = '{8'h03, 8'h7f, 8'hee, 8'hff, 8'hff, 8'h77};

  always #4 clk_sys_i = ~clk_sys_i;

  irq_flag_bank irq_flag_bank_inst (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .apb_req_i(req),
    .apb_rsp_o(rsp),
    .external_irq_zero_input_i(ext),
    .src_evt_i(src),
    .core_irq_o(core_irq),
    .irq_o(irq)
  );

  core_seq_model core_seq_model_inst (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .core_irq_i(core_irq),
    .take_cnt_o(takes)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Setup, then access until pready is seen at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    // A hang here is ended by the cycle ceiling
    do begin
      @(posedge clk_sys_i);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic pulse(input int p);
    @(posedge clk_sys_i);
    src <= src_evt_t'(15'h0001 << p);
    @(posedge clk_sys_i);
    src <= '0;
  endtask : pulse

  // Ends mid-cycle so flop outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : settle

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'(4 * i), 32'hffff_ffff);
      rd(8'(4 * i), {24'h0, RM[i]});
    end
    // Hall first, so group zero is not re-set after its clear
    for (int i = 5; i >= 0; i--) bus(1'b1, 8'(4 * i), 32'h0);
    for (int i = 0; i < 15; i++) begin
      pulse(SP[i]);
      rd(SO[i], 32'h1 << SB[i]);
      bus(1'b1, SO[i], 32'h0);
      rd(SO[i], 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h00, 32'(c));
      bus(1'b1, 8'h04, 32'h0);
      @(posedge clk_sys_i);
      ext <= 1'b1;
      settle(3);
      rd(8'h04, 32'(c & 1) << 5);
      bus(1'b1, 8'h04, 32'h0);
      @(posedge clk_sys_i);
      ext <= 1'b0;
      settle(3);
      rd(8'h04, 32'((c >> 1) & 1) << 5);
    end
    t0 = int'(takes);
    bus(1'b1, 8'h04, 32'h48);
    settle(3);
    chk({31'h0, core_irq}, 32'h0);
    bus(1'b1, 8'h04, 32'h49);
    settle(3);
    chk({31'h0, core_irq}, 32'h1);
    chk({16'h0, takes}, 32'(t0 + 1));
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h14, 32'h01);
    pulse(6);
    settle(3);
    rd(8'h14, 32'h11);
    rd(8'h04, 32'h10);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h0);
    bus(1'b1, 8'h18, 32'hff);
    bus(1'b1, 8'h1c, 32'h0);
    pulse(14);
    settle(3);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h1c, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    rd(8'h18, 32'h01);
    bus(1'b1, 8'h18, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h18, 32'h0);
    tally_and_finish();
  end
endmodule : primary_interrupt_flag_enable_bank_tb
